// [core/pin_sync.sv]
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 3
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] hold_r;

  initial
  begin
    if (WIDTH < 1)
      $error("pin_sync needs at least one bit");
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r <= '0;
      hold_r <= '0;
    end
    else
    begin
      meta_r <= pin_in;
      hold_r <= meta_r;
    end
  end

  assign pin_out = hold_r;

endmodule

// [core/resume_map.svh]
// Register offsets, field positions, reset values and timing counts
`ifndef RESUME_MAP_SVH
`define RESUME_MAP_SVH

// Clock rate
`define RS_CLK_MHZ        200
`define RS_CLK_NS         5

// Register byte offsets
`define RS_REG_CTRL       4'h0
`define RS_REG_CMD        4'h4
`define RS_REG_STATUS     4'h8
`define RS_REG_EVENT      4'hc

// Control fields
`define RS_CTRL_WAKE_EN   0
`define RS_CTRL_ATTACH    1
`define RS_CTRL_HS        2
`define RS_CTRL_RESET     3'h0

// Command fields
`define RS_CMD_WAKE       0
`define RS_CMD_SUSPEND    1

// Event fields
`define RS_EV_RESUMED     0
`define RS_EV_HOST_RESUME 1
`define RS_EV_BUS_RESET   2

// Line states and operating modes
`define RS_LS_SE0         2'h0
`define RS_LS_J           2'h1
`define RS_LS_K           2'h2
`define RS_OP_NORMAL      2'h0
`define RS_OP_NODRIVE     2'h1
`define RS_OP_NOSTUFF     2'h2

// Times in their own unit
`define RS_IDLE_MS        5
`define RS_WAKE_MAX_MS    10
`define RS_K_MIN_MS       1
`define RS_K_MAX_MS       15
`define RS_K_MS           2
`define RS_OSC_MS         6
`define RS_ATTACH_MIN_MS  100
`define RS_ATTACH_MS      110
`define RS_DEBOUNCE_MS    110
`define RS_RESTORE_NS     1250

// Cycle counts; least times round up, longest times round down
`define RS_IDLE_CYC       (`RS_IDLE_MS * 1000 * `RS_CLK_MHZ)
`define RS_WAKE_MAX_CYC   (`RS_WAKE_MAX_MS * 1000 * `RS_CLK_MHZ)
`define RS_K_MIN_CYC      (`RS_K_MIN_MS * 1000 * `RS_CLK_MHZ)
`define RS_K_MAX_CYC      (`RS_K_MAX_MS * 1000 * `RS_CLK_MHZ)
`define RS_K_CYC          (`RS_K_MS * 1000 * `RS_CLK_MHZ)
`define RS_OSC_CYC        (`RS_OSC_MS * 1000 * `RS_CLK_MHZ)
`define RS_ATTACH_MIN_CYC (`RS_ATTACH_MIN_MS * 1000 * `RS_CLK_MHZ)
`define RS_ATTACH_CYC     (`RS_ATTACH_MS * 1000 * `RS_CLK_MHZ)
`define RS_DEBOUNCE_CYC   (`RS_DEBOUNCE_MS * 1000 * `RS_CLK_MHZ)
`define RS_RESTORE_CYC    (`RS_RESTORE_NS / `RS_CLK_NS)
`define RS_FILT_CYC       4

`endif

// [core/resume_pkg.sv]
// Types shared by the resume and attach sequencer
package resume_pkg;

  typedef enum logic [9:0]
  {
    S_OFF      = 10'h001,
    S_ATTACH   = 10'h002,
    S_DEBOUNCE = 10'h004,
    S_RESET    = 10'h008,
    S_RUN      = 10'h010,
    S_SUSPEND  = 10'h020,
    S_WAKE_OSC = 10'h040,
    S_DRIVE_K  = 10'h080,
    S_WAIT_SE0 = 10'h100,
    S_HOST_K   = 10'h200
  } seq_state_e;

  typedef logic [1:0] line_t;

endpackage

// [core/seq_timer.sv]
// Loadable down counter that flags expiry of an armed interval
`timescale 1ns/1ps
module seq_timer #(
  parameter int unsigned WIDTH = 32
) (
  input  wire logic             ref_clk,
  input  wire logic             nrst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output logic                  done
);

  logic [WIDTH-1:0] cnt_r;
  logic             armed_r;
  wire  [WIDTH-1:0] cnt_dec = cnt_r - {{(WIDTH-1){1'b0}}, 1'b1};

  initial
  begin
    if (WIDTH < 2 || WIDTH > 32)
      $error("seq_timer width out of range");
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r   <= '0;
      armed_r <= 1'b0;
    end
    else if (load)
    begin
      cnt_r   <= load_val;
      armed_r <= 1'b1;
    end
    else if (cnt_r != '0)
      cnt_r <= cnt_dec;
  end

  // Unarmed counter never reports expiry
  assign done = armed_r && (cnt_r == '0);

endmodule

// [core/utmi_resume_attach_sequencer.sv]
// Controller side sequencing of suspend, resume and attach over a UTMI port
//
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "resume_map.svh"
module utmi_resume_attach_sequencer
  import resume_pkg::*;
#(
  parameter int unsigned IDLE_CYC     = `RS_IDLE_CYC,
  parameter int unsigned OSC_CYC      = `RS_OSC_CYC,
  parameter int unsigned K_CYC        = `RS_K_CYC,
  parameter int unsigned ATTACH_CYC   = `RS_ATTACH_CYC,
  parameter int unsigned DEBOUNCE_CYC = `RS_DEBOUNCE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  // Software port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata,
  // Transceiver pins
  input  wire logic [1:0]  linestate,
  input  wire logic        vbus_valid,
  output logic             suspendn,
  output logic      [1:0]  opmode,
  output logic             xcvrselect,
  output logic             termselect,
  output logic             txvalid,
  output logic      [7:0]  data_out,
  // Toward the serial engine core
  output logic             dev_reset,
  output logic             hs_start
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  initial
  begin
    if (IDLE_CYC < 1 || OSC_CYC < 1 || K_CYC < 1 || ATTACH_CYC < 1 || DEBOUNCE_CYC < 1)
      $error("sequencer counts must be at least one cycle");
    if (`RS_FILT_CYC + 4 >= `RS_RESTORE_CYC)
      $error("line filter too slow for the restore window");
  end

  // ----------------------------------------------------------------
  // Pin synchronisation and line filters
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  line_t      line_s;
  logic       vbus_s;

  pin_sync #(
    .WIDTH   (3)
  ) u_sync (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .pin_in  ({vbus_valid, linestate}),
    .pin_out (pins_s)
  );

  assign line_s = pins_s[1:0];
  assign vbus_s = pins_s[2];

  // Index 0 filters SE0, index 1 filters K; a short filter keeps glitches
  // from ending suspend while staying far inside the restore window
  localparam line_t FILT_CODE [2] = '{`RS_LS_K, `RS_LS_SE0};
  logic [1:0] seen;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_filt
      logic [2:0] run_r;
      wire        match = (line_s == FILT_CODE[1-gi]);
      wire        full  = (run_r == 3'(`RS_FILT_CYC));
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
          run_r <= '0;
        else if (!match)
          run_r <= '0;
        else if (!full)
          run_r <= run_r + 3'h1;
      end
      assign seen[gi] = full;
    end
  endgenerate

  wire se0_seen = seen[0];
  wire k_seen   = seen[1];

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic [2:0]  ctrl_r;
  logic        wake_pend_r;
  logic [2:0]  event_r;
  logic [31:0] rdata_r;
  seq_state_e  state_r;
  seq_state_e  state_nxt;

  wire wr_ctrl  = wr && (addr == `RS_REG_CTRL);
  wire wr_cmd   = wr && (addr == `RS_REG_CMD);
  wire wr_event = wr && (addr == `RS_REG_EVENT);

  wire wake_en   = ctrl_r[`RS_CTRL_WAKE_EN];
  wire attach_en = ctrl_r[`RS_CTRL_ATTACH];
  wire hs_mode   = ctrl_r[`RS_CTRL_HS];

  wire wake_cmd    = wr_cmd && wdata[`RS_CMD_WAKE];
  wire suspend_cmd = wr_cmd && wdata[`RS_CMD_SUSPEND];

  // ----------------------------------------------------------------
  // Bus idle tracking for remote wake-up
  // ----------------------------------------------------------------
  logic idle_ok;
  wire  idle_break = (state_r != S_SUSPEND) || (line_s != `RS_LS_J);

  seq_timer #(
    .WIDTH    (32)
  ) u_idle (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .load     (idle_break),
    .load_val (32'(IDLE_CYC)),
    .done     (idle_ok)
  );

  // Wake is held back until the hubs have had their idle time
  wire wake_take = (state_r == S_SUSPEND) && wake_pend_r && wake_en && idle_ok;

  // Set wins over the clear in the same cycle
  wire wake_pend_nxt = wake_cmd || (wake_pend_r && !wake_take && wake_en);

  // ----------------------------------------------------------------
  // Sequence timer
  // ----------------------------------------------------------------
  logic        seq_done;
  logic [31:0] seq_load_val;
  wire         seq_load = (state_nxt != state_r);

  always_comb
  begin
    case (state_nxt)
      S_ATTACH:   seq_load_val = 32'(ATTACH_CYC);
      S_DEBOUNCE: seq_load_val = 32'(DEBOUNCE_CYC);
      S_WAKE_OSC: seq_load_val = 32'(OSC_CYC);
      S_DRIVE_K:  seq_load_val = 32'(K_CYC);
      default:    seq_load_val = 32'h0000_0000;
    endcase
  end

  seq_timer #(
    .WIDTH    (32)
  ) u_seq (
    .ref_clk  (ref_clk),
    .nrst     (nrst),
    .load     (seq_load),
    .load_val (seq_load_val),
    .done     (seq_done)
  );

  // ----------------------------------------------------------------
  // State machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      S_OFF:
      begin
        if (vbus_s && attach_en)
          state_nxt = S_ATTACH;
      end
      S_ATTACH:
      begin
        if (seq_done)
          state_nxt = S_DEBOUNCE;
      end
      S_DEBOUNCE:
      begin
        if (seq_done && se0_seen)
          state_nxt = S_RESET;
        else if (seq_done)
          state_nxt = S_RUN;
      end
      S_RESET:
        state_nxt = S_RUN;
      S_RUN:
      begin
        if (suspend_cmd)
          state_nxt = S_SUSPEND;
      end
      S_SUSPEND:
      begin
        if (wake_take)
          state_nxt = S_WAKE_OSC;
        else if (k_seen)
          state_nxt = S_HOST_K;
        else if (se0_seen)
          state_nxt = S_RESET;
      end
      S_WAKE_OSC:
      begin
        if (seq_done)
          state_nxt = S_DRIVE_K;
      end
      S_DRIVE_K:
      begin
        if (seq_done)
          state_nxt = S_WAIT_SE0;
      end
      S_WAIT_SE0:
      begin
        if (se0_seen)
          state_nxt = S_RUN;
      end
      S_HOST_K:
      begin
        if (se0_seen)
          state_nxt = S_RUN;
      end
      default:
        state_nxt = S_OFF;
    endcase
    // Losing bus power drops the attach from any state
    if (!vbus_s || !attach_en)
      state_nxt = S_OFF;
  end

  // ----------------------------------------------------------------
  // Pin values for the coming state
  // ----------------------------------------------------------------
  logic       suspendn_nxt;
  logic [1:0] opmode_nxt;
  logic       xcvr_nxt;
  logic       term_nxt;
  logic       txvalid_nxt;

  // Pull-up stays off until attach by holding full-speed termination low
  wire attached_nxt = (state_nxt != S_OFF) && (state_nxt != S_ATTACH);
  wire fs_hold_nxt  = (state_nxt != S_RUN) || !hs_mode;
  wire k_drive_nxt  = (state_nxt == S_DRIVE_K);

  assign suspendn_nxt = (state_nxt != S_SUSPEND);
  assign opmode_nxt   = k_drive_nxt ? `RS_OP_NOSTUFF :
                        attached_nxt ? `RS_OP_NORMAL : `RS_OP_NODRIVE;
  assign xcvr_nxt     = fs_hold_nxt;
  assign term_nxt     = attached_nxt && fs_hold_nxt;
  assign txvalid_nxt  = k_drive_nxt;

  logic       suspendn_r;
  logic [1:0] opmode_r;
  logic       xcvr_r;
  logic       term_r;
  logic       txvalid_r;
  logic       dev_reset_r;
  logic       hs_start_r;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r     <= S_OFF;
      suspendn_r  <= 1'b1;
      opmode_r    <= `RS_OP_NODRIVE;
      xcvr_r      <= 1'b1;
      term_r      <= 1'b0;
      txvalid_r   <= 1'b0;
      dev_reset_r <= 1'b0;
      hs_start_r  <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      suspendn_r  <= suspendn_nxt;
      opmode_r    <= opmode_nxt;
      xcvr_r      <= xcvr_nxt;
      term_r      <= term_nxt;
      txvalid_r   <= txvalid_nxt;
      dev_reset_r <= (state_nxt == S_RESET);
      hs_start_r  <= (state_r == S_RESET) && (state_nxt == S_RUN);
    end
  end

  assign suspendn   = suspendn_r;
  assign opmode     = opmode_r;
  assign xcvrselect = xcvr_r;
  assign termselect = term_r;
  assign txvalid    = txvalid_r;
  assign data_out   = 8'h00;
  assign dev_reset  = dev_reset_r;
  assign hs_start   = hs_start_r;

  // ----------------------------------------------------------------
  // Events and register file
  // ----------------------------------------------------------------
  wire [2:0] ev_set;
  assign ev_set[`RS_EV_RESUMED]     = (state_r == S_WAIT_SE0) && (state_nxt == S_RUN);
  assign ev_set[`RS_EV_HOST_RESUME] = (state_r == S_HOST_K) && (state_nxt == S_RUN);
  assign ev_set[`RS_EV_BUS_RESET]   = (state_nxt == S_RESET) && (state_r != S_RESET);

  wire [2:0] ev_clr     = wr_event ? wdata[2:0] : 3'h0;
  wire [2:0] event_nxt  = ev_set | (event_r & ~ev_clr);
  wire [2:0] ctrl_nxt   = wr_ctrl ? wdata[2:0] : ctrl_r;

  wire [31:0] status_word = {18'h0, wake_pend_r, vbus_s, line_s, state_r};

  logic [31:0] rdata_nxt;
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    if (rd)
    begin
      case (addr)
        `RS_REG_CTRL:   rdata_nxt = {29'h0, ctrl_r};
        `RS_REG_STATUS: rdata_nxt = status_word;
        `RS_REG_EVENT:  rdata_nxt = {29'h0, event_r};
        default:        rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r      <= `RS_CTRL_RESET;
      wake_pend_r <= 1'b0;
      event_r     <= 3'h0;
      rdata_r     <= 32'h0000_0000;
    end
    else
    begin
      ctrl_r      <= ctrl_nxt;
      wake_pend_r <= wake_pend_nxt;
      event_r     <= event_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // Read data only valid in the cycle after the strobe; zero otherwise
  assign rdata = rdata_r;

endmodule

// [test/resume_assertions.sv]
// Port checker for the resume and attach sequencer
`timescale 1ns/1ps
`include "resume_map.svh"
module resume_checker #(
  parameter int unsigned IDLE_CYC     = 50,
  parameter int unsigned OSC_CYC      = 20,
  parameter int unsigned K_CYC        = 30,
  parameter int unsigned ATTACH_CYC   = 40,
  parameter int unsigned DEBOUNCE_CYC = 40
) (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  linestate,
  input wire logic        vbus_valid,
  input wire logic        suspendn,
  input wire logic [1:0]  opmode,
  input wire logic        xcvrselect,
  input wire logic        termselect,
  input wire logic        txvalid,
  input wire logic [7:0]  data_out,
  input wire logic        dev_reset,
  input wire logic        hs_start
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic        hs_r;
  logic [15:0] k_cnt_r;
  logic [15:0] vb_cnt_r;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      hs_r     <= 1'b0;
      k_cnt_r  <= 16'h0;
      vb_cnt_r <= 16'h0;
    end
    else
    begin
      if (wr && addr == `RS_REG_CTRL)
        hs_r <= wdata[`RS_CTRL_HS];
      k_cnt_r  <= txvalid ? k_cnt_r + 16'h1 : 16'h0;
      // Saturates so a long powered run never wraps
      vb_cnt_r <= !vbus_valid ? 16'h0 : (&vb_cnt_r ? vb_cnt_r : vb_cnt_r + 16'h1);
    end
  end
  sequence s_host_k;
    (linestate == `RS_LS_K) [*4];
  endsequence
  sequence s_eop;
    (linestate == `RS_LS_SE0) [*8];
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_k_fs_zero: assert property (txvalid |-> opmode == `RS_OP_NOSTUFF && xcvrselect
    && termselect && data_out == 8'h00 && suspendn) else $error("resume K framing wrong");
  a_k_width: assert property ($fell(txvalid) |-> k_cnt_r >= K_CYC
    && k_cnt_r <= K_CYC + 1 && opmode == `RS_OP_NORMAL) else $error("resume K length wrong");
  a_fs_keep: assert property (!hs_r && $fell(txvalid) |-> (xcvrselect && termselect) [*8])
    else $error("FS selects dropped after resume");
  a_hs_restore: assert property ((hs_r && xcvrselect && suspendn) ##0 s_host_k ##1 s_eop
    |-> ##[0:2] !xcvrselect && !termselect) else $error("HS not restored on SE0");
  a_k_wakes: assert property (!suspendn ##0 s_host_k |-> ##[0:6] suspendn)
    else $error("suspend kept through host K");
  a_reset_pair: assert property (dev_reset |=> hs_start && !dev_reset)
    else $error("handshake start missing after reset");
  a_start_cause: assert property (hs_start |-> $past(dev_reset))
    else $error("handshake start without reset");
  a_attach_late: assert property ($rose(termselect) && $past(opmode) == `RS_OP_NODRIVE
    |-> vb_cnt_r > ATTACH_CYC && xcvrselect && opmode == `RS_OP_NORMAL)
    else $error("attach early or not FS");
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
endmodule

bind utmi_resume_attach_sequencer resume_checker #(
  .IDLE_CYC(IDLE_CYC), .OSC_CYC(OSC_CYC), .K_CYC(K_CYC), .ATTACH_CYC(ATTACH_CYC),
  .DEBOUNCE_CYC(DEBOUNCE_CYC)
) chk_i (.*);

// [test/utmi_resume_attach_sequencer_test.sv]
// Self-checking bench for the resume and attach sequencer
`timescale 1ns/1ps
`include "resume_map.svh"
module utmi_resume_attach_sequencer_test import resume_pkg::*;;
  localparam int IDLE = 50;
  localparam int K    = 30;
  localparam int ATT  = 40;
  localparam int DEB  = 40;
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        vbus_valid = 1'b0;
  logic        host_drive = 1'b1;
  logic [1:0]  host_ls = `RS_LS_SE0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, v;
  logic [1:0]  linestate, opmode;
  logic [7:0]  data_out;
  logic        suspendn, xcvrselect, termselect, txvalid, dev_reset, hs_start;
  int          fails = 0;
  int          checked = 0;
  int          cyc = 0;
  int          t0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  utmi_resume_attach_sequencer #(.IDLE_CYC(IDLE), .OSC_CYC(20), .K_CYC(K), .ATTACH_CYC(ATT),
    .DEBOUNCE_CYC(DEB)) uut (.*);
  xcvr_model xcvr (.*);
  // ----------------------------------------
  // Access and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // EOP longer than the restore limit; state checked before it ends
  task automatic eop(input logic [31:0] ev);
    @(posedge ref_clk);
    host_ls <= `RS_LS_SE0;
    repeat (249) @(posedge ref_clk);
    rd_reg(`RS_REG_STATUS, v);
    chk(v[9:0], S_RUN);
    host_drive <= 1'b0;
    rd_reg(`RS_REG_EVENT, v);
    chk(v, ev);
    wr_reg(`RS_REG_EVENT, ev);
    rd_reg(`RS_REG_EVENT, v);
    chk(v, 32'h0);
  endtask
  task automatic print_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    #1 chk({suspendn, opmode, xcvrselect, termselect, txvalid}, {1'b1, `RS_OP_NODRIVE, 3'b100});
    rd_reg(4'h2, v);
    chk(v, 32'h0);
    $display("test reset done");
    // Host holds SE0 through debounce
    @(posedge ref_clk);
    vbus_valid <= 1'b1;
    t0 = cyc;
    wr_reg(`RS_REG_CTRL, 32'h3);
    repeat (200) if (termselect !== 1'b1) @(posedge ref_clk) #1;
    chk(cyc - t0 > ATT, 1);
    chk({xcvrselect, opmode}, {1'b1, `RS_OP_NORMAL});
    t0 = cyc;
    repeat (200) if (dev_reset !== 1'b1) @(posedge ref_clk) #1;
    chk(cyc - t0 >= DEB, 1);
    @(posedge ref_clk) #1;
    chk(hs_start, 1);
    host_drive <= 1'b0;
    // Clearing the reset event also lets the stale SE0 leave the filter before suspend
    rd_reg(`RS_REG_EVENT, v);
    chk(v, 32'h4);
    wr_reg(`RS_REG_EVENT, 32'h4);
    $display("test attach done");
    // FS remote wake-up
    wr_reg(`RS_REG_CMD, 32'h2);
    t0 = cyc;
    repeat (20) if (suspendn !== 1'b0) @(posedge ref_clk) #1;
    chk(suspendn, 0);
    wr_reg(`RS_REG_CMD, 32'h1);
    repeat (300) if (suspendn !== 1'b1) @(posedge ref_clk) #1;
    chk(cyc - t0 >= IDLE, 1);
    repeat (300) if (txvalid !== 1'b1) @(posedge ref_clk) #1;
    t0 = cyc;
    chk(linestate, `RS_LS_K);
    host_ls    <= `RS_LS_K;
    host_drive <= 1'b1;
    repeat (300) if (txvalid !== 1'b0) @(posedge ref_clk) #1;
    chk(cyc - t0 >= K, 1);
    repeat (10) @(posedge ref_clk);
    eop(32'h1);
    chk({xcvrselect, termselect, opmode}, {2'b11, `RS_OP_NORMAL});
    $display("test remote wake done");
    // HS host resume
    wr_reg(`RS_REG_CTRL, 32'h7);
    host_ls    <= `RS_LS_J;
    host_drive <= 1'b1;
    repeat (10) @(posedge ref_clk) #1;
    chk(xcvrselect, 0);
    wr_reg(`RS_REG_CMD, 32'h2);
    repeat (20) if (suspendn !== 1'b0) @(posedge ref_clk) #1;
    chk(suspendn, 0);
    host_ls <= `RS_LS_K;
    repeat (20) if (suspendn !== 1'b1) @(posedge ref_clk) #1;
    chk({suspendn, txvalid}, 2'b10);
    repeat (100) @(posedge ref_clk);
    eop(32'h2);
    chk({xcvrselect, termselect}, 2'b00);
    $display("test host resume done");
    // Host forces SE0 while suspended: bus reset path
    host_ls    <= `RS_LS_SE0;
    host_drive <= 1'b1;
    wr_reg(`RS_REG_CMD, 32'h2);
    repeat (20) if (hs_start !== 1'b1) @(posedge ref_clk) #1;
    chk(hs_start, 1);
    rd_reg(`RS_REG_EVENT, v);
    chk(v, 32'h4);
    $display("test suspend reset done");
    print_verdict();
  end
  initial
  begin
    #40000;
    fails++;
    print_verdict();
  end
endmodule

// [test/xcvr_model.sv]
// Behavioural transceiver that turns the control pins into a line state
`timescale 1ns/1ps
`include "resume_map.svh"
module xcvr_model (
  input  wire logic [1:0] opmode,
  input  wire logic       termselect,
  input  wire logic       txvalid,
  input  wire logic [7:0] data_out,
  input  wire logic       host_drive,
  input  wire logic [1:0] host_ls,
  output logic      [1:0] linestate
);
  wire k_tx = opmode == `RS_OP_NOSTUFF && txvalid && data_out == 8'h00;
  // Pull-up only with FS termination, so HS idle reads as SE0
  assign linestate = k_tx ? `RS_LS_K : host_drive ? host_ls :
                     termselect ? `RS_LS_J : `RS_LS_SE0;
endmodule
